//--- core/svw_pkg.sv
// Package for the supervisor watchdog block: register map, field positions, timing.
// Assumes one 250 MHz APB clock domain and a digital view of the analog comparators.
package svw_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_WINDOW = 8'h08;
  localparam logic [7:0] ADDR_SUPPLY = 8'h0c;
  localparam logic [7:0] ADDR_DATA_BASE = 8'h40;
  localparam int DATA_WORDS = 8;

  // Register reset values
  localparam logic [7:0] CONTROL_RESET = 8'h32;
  localparam logic [7:0] STATUS_CONTROL_RESET = 8'h1c;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CR_SENSE_SEL = 7;
  localparam int CR_NMI_HIGH = 6;
  localparam int CR_RST_LOW = 5;
  localparam int CR_NORMAL_OP = 4;
  localparam int CR_RST_EN = 1;
  localparam int SC_PWR_DOWN = 7;
  localparam int SC_WD_FLAG = 6;
  localparam int SC_PERIOD_HI = 4;
  localparam int SC_PERIOD_LO = 3;
  localparam int SC_WD_RESET = 2;
  localparam int SC_EXT_B1 = 1;
  localparam int SC_EXT_B0 = 0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SAMPLE_US = 25;
  localparam int SAMPLE_CYCLES = SAMPLE_US * CLK_MHZ;
  localparam int SAMPLE_RUN = 3;
  localparam int POR_MS = 100;
  localparam int POR_CYCLES = POR_MS * 1000 * CLK_MHZ;
  localparam int WD_P0_MS = 125;
  localparam int WD_P1_MS = 500;
  localparam int WD_P2_MS = 2000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

  typedef enum logic [1:0] {
    SVW_PER_125,
    SVW_PER_500,
    SVW_PER_2000,
    SVW_PER_OFF
  } svw_period_type;

  // Comparator results grouped as one carrier
  typedef struct packed {
    logic below_nmi_460;
    logic below_nmi_475;
    logic below_aux;
    logic below_rst_430;
    logic below_rst_450;
  } svw_supply_type;

endpackage

//--- core/svw_top.sv
// Supervisor watchdog top: APB registers, supply sensing, reset, memory protect, watchdog.
// Assumes comparator levels come asynchronously and APB runs on pclk.
module svw_top #(
  parameter bit HAS_AUX = 1'b1,
  parameter int SAMPLE_CYC = svw_pkg::SAMPLE_CYCLES,
  parameter int POR_CYC = svw_pkg::POR_CYCLES,
  parameter int TICK_CYC = svw_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparators and pins
  input wire svw_pkg::svw_supply_type supply,
  input wire logic watchdog_strobe_input_n,
  // Supervisor outputs
  output logic nmi_n,
  output logic nmi_pull_high,
  output logic sys_reset,
  output logic mem_write_protect,
  output logic mem_on_backup,
  output logic ext_supply_on_backup,
  output logic ext_chip_enable_out_n
);

  // ----------------------------------------
  // Registers and synchronisers
  // ----------------------------------------
  logic [7:0] supervisor_control;
  logic [7:0] supervisor_status_control;
  logic window_open;
  logic [7:0] data_mem [svw_pkg::DATA_WORDS];
  logic [4:0] sup_s1, sup_s2, sup_s3;
  logic [4:0] sup_filt;
  logic [2:0] strobe_sync;
  logic pf_below;
  logic [1:0] pf_run;
  logic [31:0] sample_cnt;
  logic rst_low;
  logic [31:0] por_cnt;
  logic wd_timeout;
  logic [31:0] tick_cnt;
  logic [11:0] wd_ms;
  logic wd_rst_pulse;
  logic wd_nmi;

  wire logic wr = psel && penable && pwrite;
  wire logic data_hit = paddr >= svw_pkg::ADDR_DATA_BASE &&
    paddr < svw_pkg::ADDR_DATA_BASE + 8'(4 * svw_pkg::DATA_WORDS);
  wire logic [2:0] data_idx = 3'((paddr - svw_pkg::ADDR_DATA_BASE) >> 2);
  wire logic known = data_hit || paddr == svw_pkg::ADDR_CONTROL ||
    paddr == svw_pkg::ADDR_STATUS_CONTROL || paddr == svw_pkg::ADDR_WINDOW ||
    paddr == svw_pkg::ADDR_SUPPLY;
  wire logic wr_sc = wr && paddr == svw_pkg::ADDR_STATUS_CONTROL;
  wire logic wr_win = wr && paddr == svw_pkg::ADDR_WINDOW;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;

  // ----------------------------------------
  // Input synchronisers, three stages
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_s1 <= 5'h1f;
      sup_s2 <= 5'h1f;
      sup_s3 <= 5'h1f;
      sup_filt <= 5'h1f;
      strobe_sync <= 3'h7;
    end else begin
      sup_s1 <= supply;
      sup_s2 <= sup_s1;
      sup_s3 <= sup_s2;
      // A bit moves only once stages two and three agree
      sup_filt <= (sup_s2 & sup_s3) | (sup_filt & (sup_s2 | sup_s3));
      strobe_sync <= {strobe_sync[1:0], watchdog_strobe_input_n};
    end
  end

  // Filtered levels; a glitch shorter than two cycles never reaches the logic
  wire svw_pkg::svw_supply_type sup_now = sup_filt;
  wire logic [4:0] sup_agree = ~(sup_s2 ^ sup_s3);
  logic strobe_prev;
  wire logic strobe_low = !strobe_sync[1] && !strobe_sync[2];

  // ----------------------------------------
  // Power-fail sampling
  // ----------------------------------------
  logic raw_below;
  always_comb begin
    if (supervisor_control[svw_pkg::CR_SENSE_SEL]) begin
      raw_below = HAS_AUX ? sup_now.below_aux : 1'b0;
    end else if (supervisor_control[svw_pkg::CR_NMI_HIGH]) begin
      raw_below = sup_now.below_nmi_475;
    end else begin
      raw_below = sup_now.below_nmi_460;
    end
  end
  wire logic pf_disabled = supervisor_control[svw_pkg::CR_SENSE_SEL] && !HAS_AUX;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_cnt <= '0;
      pf_run <= '0;
      pf_below <= 1'b0;
    end else if (sample_cnt == 32'(SAMPLE_CYC - 1)) begin
      sample_cnt <= '0;
      if (raw_below == pf_below || pf_disabled) begin
        pf_run <= '0;
      end else if (pf_run == 2'(svw_pkg::SAMPLE_RUN - 1)) begin
        pf_run <= '0;
        pf_below <= raw_below;
      end else begin
        pf_run <= pf_run + 2'h1;
      end
    end else begin
      sample_cnt <= sample_cnt + 32'h1;
    end
  end

  // ----------------------------------------
  // Supply reset
  // ----------------------------------------
  wire logic rst_now = supervisor_control[svw_pkg::CR_RST_LOW] ?
    sup_now.below_rst_430 : sup_now.below_rst_450;
  wire logic rst_stable = sup_agree[0] && sup_agree[1];
  wire logic nv_mode = !supervisor_control[svw_pkg::CR_RST_EN] &&
    !supervisor_control[svw_pkg::CR_NORMAL_OP];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_low <= 1'b0;
      por_cnt <= '0;
    end else begin
      if (rst_stable) begin
        rst_low <= rst_now;
      end
      if (rst_low && rst_stable && !rst_now) begin
        por_cnt <= 32'(POR_CYC);
      end else if (por_cnt != '0) begin
        por_cnt <= por_cnt - 32'h1;
      end
    end
  end

  wire logic supply_reset = supervisor_control[svw_pkg::CR_RST_EN] && !nv_mode &&
    (rst_low || por_cnt != '0);

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  wire svw_pkg::svw_period_type period = svw_pkg::svw_period_type'(
    supervisor_status_control[svw_pkg::SC_PERIOD_HI:svw_pkg::SC_PERIOD_LO]);
  logic [11:0] limit_ms;
  always_comb begin
    case (period)
      svw_pkg::SVW_PER_125: limit_ms = 12'(svw_pkg::WD_P0_MS);
      svw_pkg::SVW_PER_500: limit_ms = 12'(svw_pkg::WD_P1_MS);
      svw_pkg::SVW_PER_2000: limit_ms = 12'(svw_pkg::WD_P2_MS);
      default: limit_ms = '0;
    endcase
  end
  wire logic wd_on = period != svw_pkg::SVW_PER_OFF;
  wire logic wd_restart = (strobe_low && strobe_prev) || wr_win || wr_sc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_prev <= 1'b0;
    end else begin
      strobe_prev <= !strobe_low;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      wd_ms <= '0;
      wd_timeout <= 1'b0;
    end else begin
      wd_timeout <= 1'b0;
      if (!wd_on || wd_restart) begin
        tick_cnt <= '0;
        wd_ms <= '0;
      end else if (tick_cnt == 32'(TICK_CYC - 1)) begin
        tick_cnt <= '0;
        if (wd_ms == limit_ms - 12'h1) begin
          wd_ms <= '0;
          wd_timeout <= 1'b1;
        end else begin
          wd_ms <= wd_ms + 12'h1;
        end
      end else begin
        tick_cnt <= tick_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_rst_pulse <= 1'b0;
      wd_nmi <= 1'b0;
    end else begin
      wd_rst_pulse <= wd_timeout && supervisor_status_control[svw_pkg::SC_WD_RESET];
      if (wd_timeout && !supervisor_status_control[svw_pkg::SC_WD_RESET]) begin
        wd_nmi <= 1'b1;
      end else if (wr_win || strobe_low) begin
        wd_nmi <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Registers over APB
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supervisor_control <= svw_pkg::CONTROL_RESET;
      supervisor_status_control <= svw_pkg::STATUS_CONTROL_RESET;
      window_open <= 1'b0;
    end else begin
      if (wr && paddr == svw_pkg::ADDR_CONTROL) begin
        supervisor_control <= pwdata[7:0];
      end
      if (wr_win) begin
        window_open <= pwdata[0];
      end
      if (wr_sc) begin
        supervisor_status_control[5:0] <= pwdata[5:0];
        supervisor_status_control[svw_pkg::SC_WD_FLAG] <= pwdata[svw_pkg::SC_WD_FLAG];
      end
      // Set wins over a clear in the same cycle
      if (wd_timeout) begin
        supervisor_status_control[svw_pkg::SC_WD_FLAG] <= 1'b1;
      end
      supervisor_status_control[svw_pkg::SC_PWR_DOWN] <= pf_below;
    end
  end

  // Top-block data words; locked while supply is low
  for (genvar i = 0; i < svw_pkg::DATA_WORDS; i++) begin : g_mem
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        data_mem[i] <= 8'h00;
      end else if (wr && data_hit && data_idx == 3'(i) && !mem_write_protect) begin
        data_mem[i] <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      if (data_hit) begin
        prdata <= {24'h0, data_mem[data_idx]};
      end else if (paddr == svw_pkg::ADDR_CONTROL) begin
        prdata <= {24'h0, supervisor_control};
      end else if (paddr == svw_pkg::ADDR_STATUS_CONTROL) begin
        prdata <= {24'h0, supervisor_status_control};
      end else if (paddr == svw_pkg::ADDR_WINDOW) begin
        prdata <= {31'h0, window_open};
      end else if (paddr == svw_pkg::ADDR_SUPPLY) begin
        prdata <= {30'h0, pf_below, rst_low};
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_n <= 1'b1;
      nmi_pull_high <= 1'b0;
      sys_reset <= 1'b1;
      mem_write_protect <= 1'b1;
      mem_on_backup <= 1'b1;
      ext_supply_on_backup <= 1'b1;
      ext_chip_enable_out_n <= 1'b1;
    end else begin
      // Level interrupt while power-fail holds; status bit 7, or bit 6 for the watchdog, tells the cause
      nmi_n <= !((pf_below && !pf_disabled) || wd_nmi) || (nv_mode && rst_low);
      // Nonvolatile mode keeps the pin high while the supply is out
      nmi_pull_high <= nv_mode && rst_low;
      // Watchdog reset is one cycle; the host must latch it if it needs more
      sys_reset <= supply_reset || wd_rst_pulse;
      mem_write_protect <= rst_low;
      mem_on_backup <= rst_low;
      ext_supply_on_backup <= rst_low &&
        supervisor_status_control[svw_pkg::SC_EXT_B1:svw_pkg::SC_EXT_B0] == 2'h0;
      ext_chip_enable_out_n <= rst_low &&
        supervisor_status_control[svw_pkg::SC_EXT_B1:svw_pkg::SC_EXT_B0] == 2'h0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence wd_fire_s;
    wd_timeout;
  endsequence

  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    wd_fire_s |=> supervisor_status_control[svw_pkg::SC_WD_FLAG])
    else $error("watchdog flag not set");
  wd_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wd_fire_s and supervisor_status_control[svw_pkg::SC_WD_RESET]) |=> ##1 sys_reset)
    else $error("watchdog reset missing");
  wd_nmi_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wd_fire_s and !supervisor_status_control[svw_pkg::SC_WD_RESET]) |=> ##1 !nmi_n)
    else $error("watchdog interrupt missing");
  wd_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wd_on |=> !wd_timeout)
    else $error("timeout while disabled");
  restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    wd_restart |=> wd_ms == '0 && tick_cnt == '0)
    else $error("restart did not clear count");
  status_pd_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 supervisor_status_control[svw_pkg::SC_PWR_DOWN] == $past(pf_below))
    else $error("status bit 7 wrong");
  protect_a: assert property (@(posedge pclk) disable iff (!presetn)
    rst_low |=> mem_write_protect && mem_on_backup)
    else $error("memory not protected");
  nv_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    nv_mode && !wd_rst_pulse |=> !sys_reset)
    else $error("reset in nonvolatile mode");
  nv_nmi_a: assert property (@(posedge pclk) disable iff (!presetn)
    nv_mode && rst_low |=> nmi_n && nmi_pull_high)
    else $error("interrupt not held high");
  ext_protect_a: assert property (@(posedge pclk) disable iff (!presetn)
    rst_low && supervisor_status_control[svw_pkg::SC_EXT_B1:svw_pkg::SC_EXT_B0] == 2'h0
    |=> ext_supply_on_backup && ext_chip_enable_out_n)
    else $error("external memory not protected");
  pf_filter_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(pf_below) |-> $past(sample_cnt) == 32'(SAMPLE_CYC - 1))
    else $error("power-fail state moved off a sample");

  sequence pwr_up_s;
    rst_low && rst_stable && !rst_now;
  endsequence

  sequence rst_armed_s;
    supervisor_control[svw_pkg::CR_RST_EN] && !nv_mode;
  endsequence

  por_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pwr_up_s and rst_armed_s) |=> por_cnt != '0 ##1 sys_reset)
    else $error("power-up reset pulse missing");
endmodule

//--- sim/svw_host_model.sv
// Host side model: strobes the watchdog pin while the bench enables it.
// Assumes one pclk domain; the pin idles high through its pull-up.
module svw_host_model #(
  parameter int GAP = 100
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic strobe_en,
  // Strobe pin
  output logic watchdog_strobe_input_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Four low cycles, long enough for a three-flop input filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      watchdog_strobe_input_n <= 1'b1;
    end else begin
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      watchdog_strobe_input_n <= !(strobe_en && cnt < 4);
    end
  end
endmodule

//--- sim/tb_supervisor_watchdog_nmi.sv
// Self-checking bench for the supervisor watchdog top.
// Assumes shortened timing parameters and a host model on the strobe pin.
module tb_supervisor_watchdog_nmi;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 2;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [4:0] sup;
    logic nmi;
    logic rst;
  } svw_row_type;
  svw_row_type rows [8] = '{{8'h32, 5'b11000, 1'b1, 1'b0}, {8'h32, 5'b01000, 1'b0, 1'b0},
    {8'h72, 5'b01000, 1'b1, 1'b0}, {8'hb2, 5'b00100, 1'b1, 1'b0},
    {8'hb2, 5'b11000, 1'b0, 1'b0}, {8'h32, 5'b11001, 1'b1, 1'b0},
    {8'h12, 5'b11001, 1'b1, 1'b1}, {8'h32, 5'b11011, 1'b1, 1'b1}};
  int wd_cyc [3] = '{125 * TICK, 500 * TICK, 2000 * TICK};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  svw_pkg::svw_supply_type supply = '0;
  logic strobe_n;
  logic strobe_en = 1'b0;
  logic nmi_n;
  logic nmi_pull_high;
  logic sys_reset;
  logic mem_write_protect;
  logic mem_on_backup;
  logic ext_supply_on_backup;
  logic ext_chip_enable_out_n;
  logic [31:0] rdata;
  logic rerr;
  int n;
  int miscompares = 0;
  int check_count = 0;

  always #2 pclk = ~pclk;

  svw_top #(.SAMPLE_CYC(4), .POR_CYC(20), .TICK_CYC(TICK)) svw_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply(supply), .watchdog_strobe_input_n(strobe_n), .nmi_n(nmi_n),
    .nmi_pull_high(nmi_pull_high), .sys_reset(sys_reset),
    .mem_write_protect(mem_write_protect), .mem_on_backup(mem_on_backup),
    .ext_supply_on_backup(ext_supply_on_backup), .ext_chip_enable_out_n(ext_chip_enable_out_n));

  svw_host_model svw_host_model_i (
    .pclk(pclk), .presetn(presetn), .strobe_en(strobe_en), .watchdog_strobe_input_n(strobe_n));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_for(input bit want_nmi, input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((want_nmi ? nmi_n !== 1'b0 : sys_reset !== 1'b1) && n < lim);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (350) @(posedge pclk);
    // Supply table: thresholds, sensing source, reset level
    foreach (rows[i]) begin
      apb(1'b1, svw_pkg::ADDR_CONTROL, {24'h0, rows[i].ctrl});
      apb(1'b0, svw_pkg::ADDR_CONTROL, 32'h0);
      check(rdata, {24'h0, rows[i].ctrl});
      supply <= rows[i].sup;
      repeat (2) @(posedge pclk);
      check(nmi_n, 1'b1);
      repeat (40) @(posedge pclk);
      check(nmi_n, !rows[i].nmi);
      check(sys_reset, rows[i].rst);
      check(mem_write_protect, rows[i].rst);
      check(ext_chip_enable_out_n, rows[i].rst);
      apb(1'b0, svw_pkg::ADDR_STATUS_CONTROL, 32'h0);
      check(rdata & 32'h80, {24'h0, rows[i].nmi, 7'h0});
      supply <= '0;
      repeat (8) @(posedge pclk);
      check(sys_reset, rows[i].rst);
      repeat (80) @(posedge pclk);
      check(sys_reset, 1'b0);
      apb(1'b0, svw_pkg::ADDR_STATUS_CONTROL, 32'h0);
      check(rdata & 32'h80, 32'h0);
    end
    // Reset in mid-run: outputs at reset levels, registers back to defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(sys_reset, 1'b1);
    check(nmi_n, 1'b1);
    check(prdata, 32'h0);
    presetn <= 1'b1;
    repeat (350) @(posedge pclk);
    check(sys_reset, 1'b0);
    check(nmi_n, 1'b1);
    apb(1'b0, svw_pkg::ADDR_CONTROL, 32'h0);
    check(rdata, 32'h32);
    apb(1'b0, svw_pkg::ADDR_STATUS_CONTROL, 32'h0);
    check(rdata, 32'h1c);
    apb(1'b0, 8'h20, 32'h0);
    check(rerr, 1'b1);
    apb(1'b1, svw_pkg::ADDR_DATA_BASE + 8'h04, 32'ha5);
    apb(1'b0, svw_pkg::ADDR_DATA_BASE + 8'h04, 32'h0);
    check(rdata, 32'ha5);
    // Each of the three timed period codes (off not included), routed to the interrupt
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, svw_pkg::ADDR_STATUS_CONTROL, 32'(i << 3));
      wait_for(1'b1, 5000);
      check(32'(n >= wd_cyc[i] - 4 && n <= wd_cyc[i] + 12), 32'h1);
      apb(1'b0, svw_pkg::ADDR_STATUS_CONTROL, 32'h0);
      check(rdata & 32'h40, 32'h40);
      apb(1'b1, svw_pkg::ADDR_WINDOW, 32'h1);
      repeat (4) @(posedge pclk);
      check(nmi_n, 1'b1);
      apb(1'b1, svw_pkg::ADDR_STATUS_CONTROL, 32'h18);
      apb(1'b0, svw_pkg::ADDR_STATUS_CONTROL, 32'h0);
      check(rdata, 32'h18);
    end
    apb(1'b1, svw_pkg::ADDR_STATUS_CONTROL, 32'h0);
    strobe_en <= 1'b1;
    repeat (600) @(posedge pclk);
    check(nmi_n, 1'b1);
    apb(1'b0, svw_pkg::ADDR_STATUS_CONTROL, 32'h0);
    check(rdata & 32'h40, 32'h0);
    strobe_en <= 1'b0;
    apb(1'b1, svw_pkg::ADDR_STATUS_CONTROL, 32'h04);
    wait_for(1'b0, 400);
    check(sys_reset, 1'b1);
    check(nmi_n, 1'b1);
    apb(1'b1, svw_pkg::ADDR_STATUS_CONTROL, 32'h18);
    repeat (200) @(posedge pclk);
    check(sys_reset, 1'b0);
    // Nonvolatile mode with external control off
    apb(1'b1, svw_pkg::ADDR_CONTROL, 32'h20);
    apb(1'b1, svw_pkg::ADDR_STATUS_CONTROL, 32'h1b);
    supply <= 5'b11011;
    repeat (40) @(posedge pclk);
    check(sys_reset, 1'b0);
    check(nmi_pull_high, 1'b1);
    check(nmi_n, 1'b1);
    check(mem_on_backup, 1'b1);
    check(ext_supply_on_backup, 1'b0);
    apb(1'b1, svw_pkg::ADDR_DATA_BASE + 8'h04, 32'h5a);
    apb(1'b0, svw_pkg::ADDR_DATA_BASE + 8'h04, 32'h0);
    check(rdata, 32'ha5);
    apb(1'b0, svw_pkg::ADDR_SUPPLY, 32'h0);
    check(rdata, 32'h3);
    supply <= '0;
    repeat (80) @(posedge pclk);
    give_verdict();
  end
endmodule
